/* design/rst_seq_pkg.sv */
// Constants and types shared by the hardware reset sequencer
package rst_seq_pkg;

  // Clock rate and documented times in their own units
  localparam int CLK_MHZ      = 40;
  localparam int REJECT_US    = 5;
  localparam int ACCEPT_US    = 9;
  localparam int LOAD_MAX_MS  = 5;
  localparam int BLANK_MAX_MS = 120;
  localparam int SYNC_STAGES  = 2;

  // Cycle counts derived from the times at the clock rate
  localparam int REJECT_CYC    = REJECT_US * CLK_MHZ;
  localparam int ACCEPT_CYC    = ACCEPT_US * CLK_MHZ;
  localparam int LOAD_MAX_CYC  = LOAD_MAX_MS * 1000 * CLK_MHZ;
  localparam int BLANK_MAX_CYC = BLANK_MAX_MS * 1000 * CLK_MHZ;

  // Nonvolatile storage word map
  localparam int NVM_WORDS = 4;
  localparam int NVM_AW    = 2;
  localparam int W_ID1     = 0;
  localparam int W_ID2     = 1;
  localparam int W_ID3     = 2;
  localparam int W_COMMON_VOLTAGE_SETTING    = 3;

  // Settings held by the device
  typedef struct packed {
    logic [7:0] id1;
    logic [7:0] id2;
    logic [7:0] id3;
    logic [7:0] common_voltage_setting;
    logic       sleep_in;
    logic       display_on;
  } settings_t;

  // Hardware reset default condition
  localparam settings_t SETTINGS_DEFAULT = '{
    id1: 8'h00, id2: 8'h00, id3: 8'h00,
    common_voltage_setting: 8'h20,
    sleep_in: 1'b1, display_on: 1'b0
  };

  // Read request towards the storage
  typedef struct packed {
    logic              rd;
    logic [NVM_AW-1:0] addr;
  } nvm_req_t;

  typedef enum logic [1:0] {S_RUN, S_RESET, S_RELEASE} seq_state_t;

endpackage

/* design/nvm_loader.sv */
// Sequential reader of the stored settings words
`timescale 1ns/1ps
module nvm_loader #(
  parameter int WORDS = rst_seq_pkg::NVM_WORDS
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Control
  input  wire logic                  start,
  input  wire logic                  abort,
  output logic                       done,
  output logic [WORDS*8-1:0]         words,
  // Storage port
  output rst_seq_pkg::nvm_req_t      nvm,
  input  wire logic [7:0]            nvm_rdata,
  input  wire logic                  nvm_ack
);

  logic [7:0]                    mem [WORDS];
  logic [rst_seq_pkg::NVM_AW-1:0] idx;
  logic                          busy;

  // Walk the words, one read at a time, held until acknowledged
  always_ff @(posedge clk) begin
    if (rst || abort) begin
      busy <= 1'b0;
      idx  <= '0;
      done <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      idx  <= '0;
      done <= 1'b0;
    end else if (busy && nvm_ack) begin
      mem[idx] <= nvm_rdata;
      idx      <= idx + 1'b1;
      if (idx == rst_seq_pkg::NVM_AW'(WORDS - 1)) begin
        busy <= 1'b0;
        done <= 1'b1;                  // One-cycle completion pulse
      end
    end else begin
      done <= 1'b0;
    end
  end

  assign nvm.rd   = busy;
  assign nvm.addr = idx;

  // Present the captured words side by side
  for (genvar g = 0; g < WORDS; g++) begin : g_words
    assign words[g*8 +: 8] = mem[g];
  end

endmodule

/* design/display_hw_reset_sequencer.sv */
// Hardware reset filter, blanking and settings reload for the display
// Functional notes
// - Low reset pulses under 5 us are ignored; over 9 us always reset.
// - Pulses between 5 us and 9 us start a reset here.
// - Glitch filter stays active during a reset, spikes change nothing.
// - On release reload ids and common voltage from storage within 5 ms.
// - Display blanked in reset; awake entry blanks for at most 120 ms.
// - Reset puts every setting into its hardware reset default.
// - Release completes within 5 ms from sleep, 120 ms from awake.
`timescale 1ns/1ps
module display_hw_reset_sequencer #(
  parameter int REJECT_CYC = rst_seq_pkg::REJECT_CYC,
  parameter int LOAD_CYC   = rst_seq_pkg::LOAD_MAX_CYC,
  parameter int BLANK_CYC  = rst_seq_pkg::BLANK_MAX_CYC
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Reset pin and power state
  input  wire logic                  reset_in_n,
  input  wire logic                  sleep_in,
  // Sequencer status
  output logic                       hw_reset_pulse,
  output logic                       reset_active,
  output logic                       seq_busy,
  output logic                       seq_done,
  output logic                       display_blank,
  output logic                       blank_seq_active,
  output logic                       nvm_fault,
  output rst_seq_pkg::settings_t     settings,
  // Storage port
  output rst_seq_pkg::nvm_req_t      nvm,
  input  wire logic [7:0]            nvm_rdata,
  input  wire logic                  nvm_ack
);

  localparam int FW = $clog2(REJECT_CYC + 1);
  localparam int LW = $clog2(LOAD_CYC + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);
  // Release budget left once the high filter and synchroniser are spent
  localparam int LOAD_BUDGET =
    LOAD_CYC - REJECT_CYC - rst_seq_pkg::SYNC_STAGES - 1;
  localparam int ACCEPT_CYC  = rst_seq_pkg::ACCEPT_CYC;

  rst_seq_pkg::seq_state_t state;
  logic                    pin_meta;
  logic                    pin_sync;
  logic [FW-1:0]           flt_cnt;
  logic [LW-1:0]           rel_cnt;
  logic [BW-1:0]           blank_cnt;
  logic                    was_awake;
  logic                    load_start;
  logic                    load_done;
  logic                    load_ok;
  logic                    timeout;
  logic                    load_over;
  logic                    filt_done;
  logic [rst_seq_pkg::NVM_WORDS*8-1:0] words;

  // Two-stage synchroniser on the reset pin
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= reset_in_n;
      pin_sync <= pin_meta;
    end
  end

  // Filter counter: lows while running or releasing, highs while in reset
  assign filt_done = (flt_cnt == FW'(REJECT_CYC - 1));
  always_ff @(posedge clk) begin
    if (rst) begin
      flt_cnt <= '0;
    end else if ((state == rst_seq_pkg::S_RESET) ? !pin_sync : pin_sync) begin
      flt_cnt <= '0;
    end else if (filt_done) begin
      flt_cnt <= '0;
    end else begin
      flt_cnt <= flt_cnt + 1'b1;
    end
  end

  assign timeout = (rel_cnt == LW'(LOAD_BUDGET)) && !load_ok;

  // Load finished, or given up so a running blank timer cannot strand us
  assign load_over = load_ok || nvm_fault || timeout;

  // Sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= rst_seq_pkg::S_RUN;
    end else begin
      unique case (state)
        rst_seq_pkg::S_RUN: begin
          if (!pin_sync && filt_done) begin
            state <= rst_seq_pkg::S_RESET;
          end
        end
        rst_seq_pkg::S_RESET: begin
          if (pin_sync && filt_done) begin
            state <= rst_seq_pkg::S_RELEASE;
          end
        end
        rst_seq_pkg::S_RELEASE: begin
          if (!pin_sync && filt_done) begin
            state <= rst_seq_pkg::S_RESET;
          end else if (load_over && blank_cnt == '0) begin
            state <= rst_seq_pkg::S_RUN;
          end
        end
      endcase
    end
  end

  // Start pulse and release-time counter
  always_ff @(posedge clk) begin
    if (rst) begin
      hw_reset_pulse <= 1'b0;
      load_start     <= 1'b0;
      seq_done       <= 1'b0;
    end else begin
      hw_reset_pulse <= (state != rst_seq_pkg::S_RESET) && !pin_sync
                        && filt_done;
      load_start     <= (state == rst_seq_pkg::S_RESET) && pin_sync && filt_done;
      seq_done       <= (state == rst_seq_pkg::S_RELEASE) && load_over
                        && blank_cnt == '0 && !(!pin_sync && filt_done);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state != rst_seq_pkg::S_RELEASE) begin
      rel_cnt <= '0;
    end else if (rel_cnt != LW'(LOAD_CYC)) begin
      rel_cnt <= rel_cnt + 1'b1;
    end
  end

  // Blanking timer, armed only when reset hits an awake panel
  always_ff @(posedge clk) begin
    if (rst) begin
      blank_cnt <= '0;
      was_awake <= 1'b0;
    end else if (hw_reset_pulse) begin
      was_awake <= !sleep_in;
      blank_cnt <= sleep_in ? '0 : BW'(BLANK_CYC - LOAD_CYC);
    end else if (blank_cnt != '0) begin
      blank_cnt <= blank_cnt - 1'b1;
    end
  end

  // Load outcome and fault flag
  always_ff @(posedge clk) begin
    if (rst || hw_reset_pulse || load_start) begin
      load_ok   <= 1'b0;
      nvm_fault <= 1'b0;
    end else begin
      if (load_done) load_ok <= 1'b1;
      if (timeout) nvm_fault <= 1'b1;     // Keep defaults, flag it
    end
  end

  // Settings: defaults on reset entry, stored words on load completion
  always_ff @(posedge clk) begin
    if (rst || hw_reset_pulse) begin
      settings <= rst_seq_pkg::SETTINGS_DEFAULT;
    end else if (load_done && state == rst_seq_pkg::S_RELEASE) begin
      settings.id1 <= words[rst_seq_pkg::W_ID1*8 +: 8];
      settings.id2 <= words[rst_seq_pkg::W_ID2*8 +: 8];
      settings.id3 <= words[rst_seq_pkg::W_ID3*8 +: 8];
      settings.common_voltage_setting <= words[rst_seq_pkg::W_COMMON_VOLTAGE_SETTING*8 +: 8];
    end
  end

  nvm_loader #(
    .WORDS (rst_seq_pkg::NVM_WORDS)
  ) u_loader (
    .clk       (clk),
    .rst       (rst),
    .start     (load_start),
    .abort     (timeout || hw_reset_pulse),
    .done      (load_done),
    .words     (words),
    .nvm       (nvm),
    .nvm_rdata (nvm_rdata),
    .nvm_ack   (nvm_ack)
  );

  // Status outputs
  assign reset_active     = (state == rst_seq_pkg::S_RESET);
  assign seq_busy         = (state != rst_seq_pkg::S_RUN);
  assign display_blank    = seq_busy || !settings.display_on;
  assign blank_seq_active = (blank_cnt != '0);

  // Helper: consecutive synchronised low cycles
  logic [9:0] low_run;
  always_ff @(posedge clk) begin
    if (rst || pin_sync) low_run <= '0;
    else if (low_run != 10'h3FF) low_run <= low_run + 1'b1;
  end

  a_short_low_ignored: assert property (
    @(posedge clk) disable iff (rst)
    (state == rst_seq_pkg::S_RUN && low_run < 10'(REJECT_CYC - 1))
    |=> state == rst_seq_pkg::S_RUN)
    else $error("reset started before the low pulse was long enough");
  a_threshold_reset: assert property (
    @(posedge clk) disable iff (rst)
    (state != rst_seq_pkg::S_RESET && !pin_sync && filt_done)
    |=> reset_active && hw_reset_pulse)
    else $error("threshold low pulse did not start reset");
  a_long_low_reset: assert property (
    @(posedge clk) disable iff (rst)
    (low_run >= 10'(ACCEPT_CYC)) |-> seq_busy)
    else $error("low over accept time left device running");
  a_spike_in_reset: assert property (
    @(posedge clk) disable iff (rst)
    (reset_active && !filt_done) |=> reset_active)
    else $error("short spike ended reset");
  a_sleep_release: assert property (
    @(posedge clk) disable iff (rst)
    (state == rst_seq_pkg::S_RELEASE && !was_awake)
    |-> rel_cnt <= LW'(LOAD_BUDGET + 1))
    else $error("release from sleep exceeded budget");
  a_load_applied: assert property (
    @(posedge clk) disable iff (rst)
    (load_done && state == rst_seq_pkg::S_RELEASE) |=>
    settings.common_voltage_setting ==
    $past(words[rst_seq_pkg::W_COMMON_VOLTAGE_SETTING*8 +: 8]))
    else $error("stored voltage setting not applied");
  a_blank_in_reset: assert property (
    @(posedge clk) disable iff (rst)
    seq_busy |-> display_blank)
    else $error("display not blanked during reset");
  a_awake_blanking: assert property (
    @(posedge clk) disable iff (rst)
    hw_reset_pulse |=> blank_seq_active == !$past(sleep_in))
    else $error("blanking sequence mismatch with power state");
  a_default_entry: assert property (
    @(posedge clk) disable iff (rst)
    hw_reset_pulse |=> settings.sleep_in && !settings.display_on)
    else $error("settings not at defaults after reset");

  c_awake_reset: cover property (@(posedge clk) disable iff (rst)
    hw_reset_pulse && !sleep_in);
  c_sleep_reset: cover property (@(posedge clk) disable iff (rst)
    hw_reset_pulse && sleep_in);
  c_spike_reject: cover property (@(posedge clk) disable iff (rst)
    state == rst_seq_pkg::S_RUN && !pin_sync ##1 pin_sync);
  c_seq_done: cover property (@(posedge clk) disable iff (rst) seq_done);

endmodule

/* verification/settings_store_model.sv */
// Behavioural model of the settings storage answering word reads
`timescale 1ns/1ps
module settings_store_model (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Read request and answer
  input  wire rst_seq_pkg::nvm_req_t nvm,
  output logic [7:0]                 rdata,
  output logic                       ack,
  // Answer pacing: wait cycles per word, or never answer
  input  wire logic [3:0]            delay,
  input  wire logic                  mute
);
  logic [3:0] wait_cnt;

  // One ack per word after the wait; data scrambled while not valid
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_cnt <= 4'h0;
      ack      <= 1'b0;
      rdata    <= 8'h00;
    end else if (nvm.rd && !ack && !mute && wait_cnt >= delay) begin
      ack      <= 1'b1;
      rdata    <= {6'h30, nvm.addr}; // Word n holds C0 plus n
      wait_cnt <= 4'h0;
    end else begin
      ack   <= 1'b0;
      rdata <= ~rdata;
      if (nvm.rd && !ack && wait_cnt != 4'hF) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

/* verification/display_hw_reset_sequencer_test.sv */
// Self-checking bench for the hardware reset sequencer
`timescale 1ns/1ps
module display_hw_reset_sequencer_test;
  localparam int R     = 8;
  localparam int LOAD  = 400;
  localparam int BLANK = 1000;
  localparam rst_seq_pkg::settings_t LOADED = '{
    id1: 8'hC0, id2: 8'hC1, id3: 8'hC2,
    common_voltage_setting: 8'hC3, sleep_in: 1'b1, display_on: 1'b0
  };

  logic                   clk        = 1'b0;
  logic                   rst        = 1'b1;
  logic                   reset_in_n = 1'b1;
  logic                   sleep_in   = 1'b1;
  logic [3:0]             delay      = 4'h0;
  logic                   mute       = 1'b0;
  logic                   hw_reset_pulse;
  logic                   reset_active;
  logic                   seq_busy;
  logic                   seq_done;
  logic                   display_blank;
  logic                   blank_seq_active;
  logic                   nvm_fault;
  rst_seq_pkg::settings_t settings;
  rst_seq_pkg::nvm_req_t  nvm;
  logic [7:0]             nvm_rdata;
  logic                   nvm_ack;
  int                     num_errors      = 0;
  int                     samples_checked = 0;
  int                     pulses          = 0;

  // Clock and count of reset start pulses
  always #12.5 clk = ~clk;
  always @(posedge clk) if (hw_reset_pulse === 1'b1) pulses <= pulses + 1;

  display_hw_reset_sequencer #(
    .REJECT_CYC (R),
    .LOAD_CYC   (LOAD),
    .BLANK_CYC  (BLANK)
  ) u_dut (
    .clk              (clk),
    .rst              (rst),
    .reset_in_n       (reset_in_n),
    .sleep_in         (sleep_in),
    .hw_reset_pulse   (hw_reset_pulse),
    .reset_active     (reset_active),
    .seq_busy         (seq_busy),
    .seq_done         (seq_done),
    .display_blank    (display_blank),
    .blank_seq_active (blank_seq_active),
    .nvm_fault        (nvm_fault),
    .settings         (settings),
    .nvm              (nvm),
    .nvm_rdata        (nvm_rdata),
    .nvm_ack          (nvm_ack)
  );

  settings_store_model u_store (
    .clk   (clk),
    .rst   (rst),
    .nvm   (nvm),
    .rdata (nvm_rdata),
    .ack   (nvm_ack),
    .delay (delay),
    .mute  (mute)
  );

  // Compare one value and report a mismatch
  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Short low pulse on the pin must leave no trace
  task automatic glitch(input int n);
    int p;
    p = pulses;
    reset_in_n = 1'b0;
    repeat (n) @(negedge clk);
    reset_in_n = 1'b1;
    repeat (R + 6) @(negedge clk);
    check("glitch_pulses", pulses - p, 0);
    check("glitch_active", reset_active, 1'b0);
  endtask

  // Full reset, optional spike inside it, release and reload
  task automatic run_reset(input logic sleep, input logic spike,
                           input int limit, input logic fault,
                           input int hold);
    int n;
    int p;
    p = pulses;
    n = 0;
    sleep_in = sleep;
    reset_in_n = 1'b0;
    repeat (hold) @(negedge clk);
    check("reset_active", reset_active, 1'b1);
    check("display_blank", display_blank, 1'b1);
    check("blank_seq_active", blank_seq_active, !sleep);
    check("settings_default", settings, rst_seq_pkg::SETTINGS_DEFAULT);
    if (spike) begin
      reset_in_n = 1'b1;
      repeat (R - 2) @(negedge clk);
      reset_in_n = 1'b0;
      repeat (R + 4) begin
        @(negedge clk);
        if (reset_active !== 1'b1) n++;
      end
      check("spike_drops", n, 0);
    end
    reset_in_n = 1'b1;
    n = 0;
    while (seq_done !== 1'b1 && n < limit + 20) begin
      @(negedge clk);
      n++;
    end
    check("start_pulses", pulses - p, 1);
    check("release_in_time", n <= limit, 1'b1);
    check("busy_after", seq_busy, 1'b0);
    if (fault) begin
      check("nvm_fault", nvm_fault, 1'b1);
      check("fault_settings", settings, rst_seq_pkg::SETTINGS_DEFAULT);
    end else begin
      check("settings_loaded", settings, LOADED);
      check("no_fault", nvm_fault, 1'b0);
    end
    // Host holds off commands, then any wake-up, after release
    repeat (LOAD) @(negedge clk);
    repeat (BLANK - LOAD) @(negedge clk);
  endtask

  // Long low while the reload is under way must restart the reset
  task automatic reset_again;
    int n;
    int p;
    p = pulses;
    reset_in_n = 1'b0;
    repeat (R + 4) @(negedge clk);
    reset_in_n = 1'b1;
    repeat (R + 6) @(negedge clk);
    reset_in_n = 1'b0;
    repeat (R + 4) @(negedge clk);
    check("rerun_active", reset_active, 1'b1);
    check("rerun_pulses", pulses - p, 2);
    reset_in_n = 1'b1;
    n = 0;
    while (seq_done !== 1'b1 && n < LOAD + 20) begin
      @(negedge clk);
      n++;
    end
    check("rerun_in_time", n <= LOAD, 1'b1);
    check("rerun_settings", settings, LOADED);
    repeat (LOAD) @(negedge clk);
    repeat (BLANK - LOAD) @(negedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset_settings", settings, rst_seq_pkg::SETTINGS_DEFAULT);
    check("reset_blank", display_blank, 1'b1);
    glitch(R - 1);
    glitch(2);
    run_reset(1'b1, 1'b0, LOAD, 1'b0, R + 4);
    delay = 4'h5;
    reset_again;
    run_reset(1'b0, 1'b1, BLANK, 1'b0, R + 4);
    mute = 1'b1;
    run_reset(1'b1, 1'b0, LOAD, 1'b1, rst_seq_pkg::ACCEPT_CYC + 40);
    conclude;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule
